// ==== include/ppm_consts.svh ====
// Constants of the panel power-management block: offsets, fields,
// reset values and timing counts.
// Assumes a 250 MHz core clock and an 8-bit register port.
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH

// ----------------------------------------------------------------
// Register port widths and offsets
// ----------------------------------------------------------------
`define PPM_ADDR_W        8
`define PPM_DATA_W        8
`define PPM_OFS_CTRL      8'h20
`define PPM_OFS_DEBOUNCE  8'h21
`define PPM_OFS_POLARITY  8'h08
`define PPM_OFS_TIMEOUT   8'h22
`define PPM_OFS_STATUS    8'h23

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PPM_CTRL_STB_DIR  7
`define PPM_CTRL_PANEL_EN 6
`define PPM_CTRL_MON_EN   5
`define PPM_CTRL_ACT_EN   0
`define PPM_POL_SUSPEND   3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PPM_RST_CTRL      8'h00
`define PPM_RST_DEBOUNCE  8'h00
`define PPM_RST_POLARITY  8'h00
`define PPM_RST_TIMEOUT   8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PPM_CLK_MHZ       250
`define PPM_TICK_TIME_US  1000
`define PPM_TICK_CYCLES   (`PPM_TICK_TIME_US * `PPM_CLK_MHZ)
`define PPM_PRESC_W       18
`define PPM_STEP_TICKS    4

`endif

// ==== include/ppm_pkg.sv ====
// Types of the panel power-management block.
// Assumes ppm_consts.svh for the widths.
`include "ppm_consts.svh"

package ppm_pkg;

  // Register port request
  typedef struct packed {
    logic [`PPM_ADDR_W-1:0] addr;
    logic [`PPM_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } ppm_bus_req_t;

  // Panel power switch enables
  typedef struct packed {
    logic panel_backlight_en;
    logic panel_bias_power_en;
    logic panel_logic_power_en;
  } ppm_panel_pwr_t;

  // Sequencer steps, panel fully off to fully on
  typedef enum logic [1:0] {
    PPM_SEQ_OFF,
    PPM_SEQ_LOGIC,
    PPM_SEQ_BIAS,
    PPM_SEQ_FULL
  } ppm_seq_st_t;

  typedef struct packed {
    ppm_seq_st_t            st;
    logic [3:0]             cnt;
    ppm_panel_pwr_t         pwr;
  } ppm_seq_state_t;

endpackage

// ==== rtl/ppm_ctrl.sv ====
// Panel power-management control: register port, input sensing,
// idle timer, suspend debounce, standby pin and panel sequencing.
// Assumes all pins are sampled on sys_clk; pad pulls sit outside.
//
// What this block does
// - Unmasked activity rising edge restarts the power-down timers.
// - Drive backlight, logic and bias enables through sequencing.
// - Shutdown falling edge clears panel and monitor enable bits.
// - That clear starts panel power-down and halts memory refresh.
// - Shutdown rising edge restores nothing; software rewrites bits.
// - Shutdown input idles high, so a floating pin causes no shutdown.
// - AC power present freezes timers; they cannot start power-down.
// - AC power removed lets timers continue from the frozen count.
// - AC power input idles low, so timers run when unconnected.
// - Control bit seven sets standby pin direction: 1 is output.
// - As input, a high standby pin starts power-down to standby.
// - As output, standby pin is high exactly while in standby.
// - Suspend input is polarity set, debounced, then powers panel off.
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "ppm_consts.svh"

module ppm_ctrl #(
  parameter int TICK_CYCLES = `PPM_TICK_CYCLES,
  parameter int STEP_TICKS  = `PPM_STEP_TICKS
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  ppm_pkg::ppm_bus_req_t        bus_req,
  output logic [`PPM_DATA_W-1:0]       bus_rdata,
  input  wire logic                    activity_sense_in,
  input  wire logic                    panel_shutdown_n,
  input  wire logic                    ac_power_present,
  input  wire logic                    suspend_in,
  input  wire logic                    standby_pin_in,
  output logic                         standby_pin_out,
  output logic                         standby_pin_oe,
  output ppm_pkg::ppm_panel_pwr_t      panel_pwr,
  output logic                         monitor_en,
  output logic                         refresh_halt,
  output logic                         standby_mode,
  output logic                         suspend_mode
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                      act_s1;
    logic                      act_s2;
    logic                      act_prev;
    logic                      shd_s1;
    logic                      shd_s2;
    logic                      shd_prev;
    logic                      ac_s1;
    logic                      ac_s2;
    logic                      stb_s1;
    logic                      stb_s2;
    logic                      sus_s1;
    logic                      sus_s2;
    logic [`PPM_DATA_W-1:0]    ctrl;
    logic [`PPM_DATA_W-1:0]    debounce;
    logic [`PPM_DATA_W-1:0]    polarity;
    logic [`PPM_DATA_W-1:0]    timeout;
    logic [`PPM_PRESC_W-1:0]   presc;
    logic                      tick;
    logic [`PPM_DATA_W-1:0]    idle;
    logic                      expired;
    logic [3:0]                sus_cnt;
    logic                      sus_state;
    logic                      refresh_halt;
    logic                      standby;
    logic                      stb_out;
    logic                      stb_oe;
    logic [`PPM_DATA_W-1:0]    rdata;
  } ppm_ctrl_state_t;

  ppm_ctrl_state_t s_r;
  ppm_ctrl_state_t s_nxt;

  // Combinational helpers
  logic act_rise;
  logic shd_fall;
  logic sus_raw;
  logic stb_req;
  logic panel_on_req;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Address match, used by both the write and the read decoders
  function automatic logic hit(
    input logic [`PPM_ADDR_W-1:0] a,
    input logic [`PPM_ADDR_W-1:0] ofs
  );
    return a == ofs;
  endfunction

  // Saturating-free increment of an 8-bit count
  function automatic logic [`PPM_DATA_W-1:0] inc8(
    input logic [`PPM_DATA_W-1:0] v
  );
    return v + `PPM_DATA_W'(1);
  endfunction

  // ----------------------------------------------------------------
  // Edge and level detection on the synchronised copies
  // ----------------------------------------------------------------
  // Only the second stage is looked at; the first may be metastable
  assign act_rise = s_r.act_s2 & ~s_r.act_prev;
  assign shd_fall = ~s_r.shd_s2 & s_r.shd_prev;
  // Polarity bit set means the suspend pin is active low
  assign sus_raw  = s_r.sus_s2 ^ s_r.polarity[`PPM_POL_SUSPEND];
  // Standby pin acts as a request only while it is an input
  assign stb_req  = ~s_r.ctrl[`PPM_CTRL_STB_DIR] & s_r.stb_s2;
  // Panel is wanted while enabled and in neither low-power mode
  assign panel_on_req = s_r.ctrl[`PPM_CTRL_PANEL_EN]
                      & ~s_r.standby
                      & ~s_r.sus_state;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;

    // Two-stage synchronisers and edge history
    s_nxt.act_s1   = activity_sense_in;
    s_nxt.act_s2   = s_r.act_s1;
    s_nxt.act_prev = s_r.act_s2;
    s_nxt.shd_s1   = panel_shutdown_n;
    s_nxt.shd_s2   = s_r.shd_s1;
    s_nxt.shd_prev = s_r.shd_s2;
    s_nxt.ac_s1    = ac_power_present;
    s_nxt.ac_s2    = s_r.ac_s1;
    s_nxt.stb_s1   = standby_pin_in;
    s_nxt.stb_s2   = s_r.stb_s1;
    s_nxt.sus_s1   = suspend_in;
    s_nxt.sus_s2   = s_r.sus_s1;

    // Millisecond prescaler shared by timers, debounce and sequencer
    if (s_r.presc == `PPM_PRESC_W'(TICK_CYCLES - 1))
    begin
      s_nxt.presc = '0;
      s_nxt.tick  = 1'b1;
    end
    else
    begin
      s_nxt.presc = s_r.presc + `PPM_PRESC_W'(1);
      s_nxt.tick  = 1'b0;
    end

    // Register writes
    if (bus_req.wr)
    begin
      if (hit(bus_req.addr, `PPM_OFS_CTRL))
      begin
        s_nxt.ctrl = bus_req.wdata;
        // Turning an enable back on is how software resumes refresh
        if (bus_req.wdata[`PPM_CTRL_PANEL_EN]
            || bus_req.wdata[`PPM_CTRL_MON_EN])
          s_nxt.refresh_halt = 1'b0;
      end
      else if (hit(bus_req.addr, `PPM_OFS_DEBOUNCE))
        s_nxt.debounce = bus_req.wdata;
      else if (hit(bus_req.addr, `PPM_OFS_POLARITY))
        s_nxt.polarity = bus_req.wdata;
      else if (hit(bus_req.addr, `PPM_OFS_TIMEOUT))
      begin
        s_nxt.timeout = bus_req.wdata;
        s_nxt.idle    = '0;
        s_nxt.expired = 1'b0;
      end
    end

    // Shutdown edge beats a same-cycle write: safety over software.
    // A rising edge has no branch here, so the bits stay cleared.
    if (shd_fall)
    begin
      s_nxt.ctrl[`PPM_CTRL_PANEL_EN] = 1'b0;
      s_nxt.ctrl[`PPM_CTRL_MON_EN]   = 1'b0;
      s_nxt.refresh_halt             = 1'b1;
    end

    // Idle timer: activity restart first, then AC freeze, then count
    if (act_rise && s_r.ctrl[`PPM_CTRL_ACT_EN])
    begin
      s_nxt.idle    = '0;
      s_nxt.expired = 1'b0;
    end
    else if (s_r.ac_s2)
    begin
      // Count and expiry held; on release counting picks up here
      s_nxt.idle    = s_r.idle;
      s_nxt.expired = s_r.expired;
    end
    else if (s_r.timeout == '0)
    begin
      // Zero timeout turns the timer off
      s_nxt.idle    = '0;
      s_nxt.expired = 1'b0;
    end
    else if (s_r.tick && !s_r.expired)
    begin
      s_nxt.idle = inc8(s_r.idle);
      if (inc8(s_r.idle) >= s_r.timeout)
        s_nxt.expired = 1'b1;
    end

    // Suspend debounce: the new level must hold for the set ticks
    if (sus_raw == s_r.sus_state)
      s_nxt.sus_cnt = 4'h0;
    else if (s_r.sus_cnt >= s_r.debounce[3:0])
    begin
      s_nxt.sus_state = sus_raw;
      s_nxt.sus_cnt   = 4'h0;
    end
    else if (s_r.tick)
      s_nxt.sus_cnt = s_r.sus_cnt + 4'h1;

    // Standby mode from the idle timer or from the pin request;
    // an AC-frozen timer keeps whatever it had already decided
    s_nxt.standby = s_r.expired | stb_req;

    // Standby pin driver: enable from direction, level from mode
    s_nxt.stb_oe  = s_nxt.ctrl[`PPM_CTRL_STB_DIR];
    s_nxt.stb_out = s_nxt.ctrl[`PPM_CTRL_STB_DIR]
                  & s_nxt.standby;

    // Read data stands only in the cycle after the strobe
    s_nxt.rdata = '0;
    if (bus_req.rd)
    begin
      if (hit(bus_req.addr, `PPM_OFS_CTRL))
        s_nxt.rdata = s_r.ctrl;
      else if (hit(bus_req.addr, `PPM_OFS_DEBOUNCE))
        s_nxt.rdata = {4'h0, s_r.debounce[3:0]};
      else if (hit(bus_req.addr, `PPM_OFS_POLARITY))
        s_nxt.rdata = s_r.polarity;
      else if (hit(bus_req.addr, `PPM_OFS_TIMEOUT))
        s_nxt.rdata = s_r.timeout;
      else if (hit(bus_req.addr, `PPM_OFS_STATUS))
        s_nxt.rdata = {2'h0,
                       s_r.shd_s2,
                       s_r.ac_s2,
                       s_r.expired,
                       s_r.refresh_halt,
                       s_r.sus_state,
                       s_r.standby};
      else
        s_nxt.rdata = '0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Shutdown copies reset high and AC copies low, matching the pad
  // pulls, so an open pin gives neither a false edge nor a freeze
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_r          <= '0;
      s_r.shd_s1   <= 1'b1;
      s_r.shd_s2   <= 1'b1;
      s_r.shd_prev <= 1'b1;
      s_r.ac_s1    <= 1'b0;
      s_r.ac_s2    <= 1'b0;
      s_r.ctrl     <= `PPM_RST_CTRL;
      s_r.debounce <= `PPM_RST_DEBOUNCE;
      s_r.polarity <= `PPM_RST_POLARITY;
      s_r.timeout  <= `PPM_RST_TIMEOUT;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Panel power sequencer
  // ----------------------------------------------------------------
  ppm_seq #(
    .STEP_TICKS   (STEP_TICKS)
  ) u_seq (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .step_tick    (s_r.tick),
    .power_on_req (panel_on_req),
    .panel_pwr    (panel_pwr)
  );

  // ----------------------------------------------------------------
  // Outputs, each straight from a flop
  // ----------------------------------------------------------------
  assign bus_rdata       = s_r.rdata;
  assign standby_pin_out = s_r.stb_out;
  assign standby_pin_oe  = s_r.stb_oe;
  assign monitor_en      = s_r.ctrl[`PPM_CTRL_MON_EN];
  assign refresh_halt    = s_r.refresh_halt;
  assign standby_mode    = s_r.standby;
  assign suspend_mode    = s_r.sus_state;

endmodule

// ==== rtl/ppm_seq.sv ====
// Panel power sequencer: walks the three enables one step at a time.
// Assumes a one-cycle step tick from the owner of the prescaler.
`timescale 1ns/1ps
`include "ppm_consts.svh"

module ppm_seq #(
  parameter int STEP_TICKS = `PPM_STEP_TICKS
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    step_tick,
  input  wire logic                    power_on_req,
  output ppm_pkg::ppm_panel_pwr_t      panel_pwr
);

  ppm_pkg::ppm_seq_state_t s_r;
  ppm_pkg::ppm_seq_state_t s_nxt;

  // ----------------------------------------------------------------
  // Step machine
  // ----------------------------------------------------------------
  // Backlight drops first and comes up last, so the panel never
  // shows an unpowered image
  always_comb
  begin
    s_nxt = s_r;
    if (step_tick)
    begin
      if (s_r.cnt != 4'(STEP_TICKS - 1))
        s_nxt.cnt = s_r.cnt + 4'h1;
      else
      begin
        s_nxt.cnt = 4'h0;
        case (s_r.st)
          ppm_pkg::PPM_SEQ_OFF:
            if (power_on_req) s_nxt.st = ppm_pkg::PPM_SEQ_LOGIC;
          ppm_pkg::PPM_SEQ_LOGIC:
            s_nxt.st = power_on_req ? ppm_pkg::PPM_SEQ_BIAS
                                    : ppm_pkg::PPM_SEQ_OFF;
          ppm_pkg::PPM_SEQ_BIAS:
            s_nxt.st = power_on_req ? ppm_pkg::PPM_SEQ_FULL
                                    : ppm_pkg::PPM_SEQ_LOGIC;
          default:
            if (!power_on_req) s_nxt.st = ppm_pkg::PPM_SEQ_BIAS;
        endcase
      end
    end
    // Enables follow the step taken, so they leave a flop directly
    s_nxt.pwr.panel_logic_power_en = (s_nxt.st != ppm_pkg::PPM_SEQ_OFF);
    s_nxt.pwr.panel_bias_power_en  = (s_nxt.st == ppm_pkg::PPM_SEQ_BIAS)
                                   || (s_nxt.st == ppm_pkg::PPM_SEQ_FULL);
    s_nxt.pwr.panel_backlight_en   = (s_nxt.st == ppm_pkg::PPM_SEQ_FULL);
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      s_r <= '{st: ppm_pkg::PPM_SEQ_OFF, cnt: 4'h0, pwr: 3'h0};
    else
      s_r <= s_nxt;
  end

  assign panel_pwr = s_r.pwr;

endmodule

// ==== tb/ppm_ctrl_sva.sv ====
// Checker for the panel power-management block, bound to its top.
// Assumes ppm_pkg is compiled first and one clock domain on sys_clk.
`timescale 1ns/1ps
`include "ppm_consts.svh"

module ppm_ctrl_chk #(
  parameter int TICK_CYCLES = `PPM_TICK_CYCLES,
  parameter int STEP_TICKS  = `PPM_STEP_TICKS
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  ppm_pkg::ppm_bus_req_t  bus_req,
  input  wire logic [7:0]        bus_rdata,
  input  wire logic              activity_sense_in,
  input  wire logic              panel_shutdown_n,
  input  wire logic              ac_power_present,
  input  wire logic              suspend_in,
  input  wire logic              standby_pin_in,
  input  wire logic              standby_pin_out,
  input  wire logic              standby_pin_oe,
  input  ppm_pkg::ppm_panel_pwr_t panel_pwr,
  input  wire logic              monitor_en,
  input  wire logic              refresh_halt,
  input  wire logic              standby_mode,
  input  wire logic              suspend_mode
);
  // ----------------------------------------------------------------
  // Helper terms
  // ----------------------------------------------------------------
  logic en_wr;

  // Only a control write that sets an enable may lift the refresh halt
  assign en_wr = bus_req.wr && bus_req.addr == `PPM_OFS_CTRL &&
                 (bus_req.wdata[6] || bus_req.wdata[5]);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_OE_FOLLOWS_DIR: assert property (
    bus_req.wr && bus_req.addr == `PPM_OFS_CTRL |-> ##2
    standby_pin_oe == $past(bus_req.wdata[`PPM_CTRL_STB_DIR], 2))
    else $error("standby pin direction not taken from control bit");
  AST_OUT_NEEDS_STBY: assert property (
    standby_pin_out |-> standby_mode || $past(standby_mode))
    else $error("standby pin high outside standby");
  AST_OUT_LOW_IDLE: assert property (
    !standby_mode [*2] |-> !standby_pin_out)
    else $error("standby pin stays high after standby ended");
  AST_SHDN_CLEARS: assert property (
    $fell(panel_shutdown_n) |-> ##[3:5] !monitor_en && refresh_halt)
    else $error("shutdown edge did not clear enables and halt refresh");
  AST_HALT_HOLDS: assert property (
    (refresh_halt && !en_wr) [*2] |=> refresh_halt)
    else $error("refresh halt dropped without an enabling write");
  AST_NO_REENABLE: assert property (
    (!monitor_en && !bus_req.wr) [*2] |=> !monitor_en)
    else $error("monitor enable came back without a write");
  AST_DOWN_ORDER: assert property (
    $fell(panel_pwr.panel_logic_power_en) |->
    !panel_pwr.panel_bias_power_en && !panel_pwr.panel_backlight_en)
    else $error("logic power dropped before bias or backlight");
  AST_UP_ORDER: assert property (
    $rose(panel_pwr.panel_backlight_en) |->
    panel_pwr.panel_bias_power_en && panel_pwr.panel_logic_power_en)
    else $error("backlight rose before bias and logic power");
  AST_AC_FREEZE: assert property (
    ac_power_present [*6] ##1 standby_pin_oe |-> !$rose(standby_mode))
    else $error("standby entered while AC power present");
endmodule

bind ppm_ctrl ppm_ctrl_chk #(
  .TICK_CYCLES (TICK_CYCLES),
  .STEP_TICKS  (STEP_TICKS)
) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .activity_sense_in(activity_sense_in),
  .panel_shutdown_n(panel_shutdown_n),
  .ac_power_present(ac_power_present), .suspend_in(suspend_in),
  .standby_pin_in(standby_pin_in), .standby_pin_out(standby_pin_out),
  .standby_pin_oe(standby_pin_oe), .panel_pwr(panel_pwr),
  .monitor_en(monitor_en), .refresh_halt(refresh_halt),
  .standby_mode(standby_mode), .suspend_mode(suspend_mode)
);

// ==== tb/ppm_panel_model.sv ====
// Far side: pad pulls, standby pin wire and panel power switches.
// Assumes the bench changes its requests just after rising edges.
`timescale 1ns/1ps

module ppm_panel_model (
  input  wire logic               sys_clk,
  input  ppm_pkg::ppm_panel_pwr_t panel_pwr,
  input  wire logic               standby_pin_out,
  input  wire logic               standby_pin_oe,
  input  wire logic               shdn_pull_low,
  input  wire logic               stb_drive,
  output logic                    panel_shutdown_n,
  output logic                    standby_pin_in,
  output logic                    order_err
);
  // Pull-up wins whenever nobody pulls the shutdown line low
  assign panel_shutdown_n = !shdn_pull_low;
  // Device drive beats the weak external level on the standby wire
  assign standby_pin_in = standby_pin_oe ? standby_pin_out : stb_drive;

  // Switches flag an enable that is on without its supply below it
  initial order_err = 1'h0;
  always @(posedge sys_clk)
  begin
    if ((panel_pwr.panel_backlight_en && !panel_pwr.panel_bias_power_en) ||
        (panel_pwr.panel_bias_power_en && !panel_pwr.panel_logic_power_en))
      order_err <= 1'h1;
  end
endmodule

// ==== tb/test_panel_power_mgmt_control.sv ====
// Self-checking bench for the panel power-management block.
// Assumes the checker bind and far-side model are compiled beforehand.
`timescale 1ns/1ps
`include "ppm_consts.svh"

module test_panel_power_mgmt_control;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  ppm_pkg::ppm_bus_req_t bus_req = '0;
  ppm_pkg::ppm_panel_pwr_t panel_pwr;
  logic [7:0] bus_rdata;
  logic act = 1'h0, ac = 1'h0, susp = 1'h0, shdn_low = 1'h0, stb_lvl = 1'h0;
  logic shdn_n, stb_in, stb_out, stb_oe, monitor_en, refresh_halt;
  logic standby_mode, suspend_mode, order_err;
  int errors = 0;
  int samples_checked = 0;

  // Short tick and step keep the power-down timers quick in simulation
  ppm_ctrl #(.TICK_CYCLES(8), .STEP_TICKS(1)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .activity_sense_in(act),
    .panel_shutdown_n(shdn_n), .ac_power_present(ac), .suspend_in(susp),
    .standby_pin_in(stb_in), .standby_pin_out(stb_out),
    .standby_pin_oe(stb_oe), .panel_pwr(panel_pwr),
    .monitor_en(monitor_en), .refresh_halt(refresh_halt),
    .standby_mode(standby_mode), .suspend_mode(suspend_mode));

  ppm_panel_model u_model (
    .sys_clk(sys_clk), .panel_pwr(panel_pwr), .standby_pin_out(stb_out),
    .standby_pin_oe(stb_oe), .shdn_pull_low(shdn_low),
    .stb_drive(stb_lvl), .panel_shutdown_n(shdn_n),
    .standby_pin_in(stb_in), .order_err(order_err));

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One-cycle strobes; a quiet cycle follows so no signal is set twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= {a, d, 1'h1, 1'h0};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] exp);
    @(posedge sys_clk);
    bus_req <= {a, 8'h00, 1'h0, 1'h1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    chk(bus_rdata & m, exp);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: pick = standby_mode;
      1: pick = refresh_halt;
      2: pick = suspend_mode;
      3: pick = (panel_pwr === 3'h7);
      default: pick = (panel_pwr === 3'h0);
    endcase
  endfunction

  // Bounded wait for a level, then judge it
  task automatic await(input int s, input logic v, input int n);
    for (int i = 0; i < n && pick(s) !== v; i++)
      @(posedge sys_clk);
    chk({7'h00, pick(s)}, {7'h00, v});
  endtask

  task automatic pulse_act;
    @(posedge sys_clk);
    act <= 1'h1;
    cyc(4);
    act <= 1'h0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdchk(`PPM_OFS_CTRL, 8'hFF, 8'h00);
    rdchk(`PPM_OFS_STATUS, 8'h20, 8'h20);
    // Read data must fall back to zero one cycle after it stood
    cyc(1);
    #1;
    chk(bus_rdata, 8'h00);
    rdchk(`PPM_OFS_STATUS, 8'h10, 8'h00);
    rdchk(8'h7E, 8'hFF, 8'h00);
    wr(`PPM_OFS_DEBOUNCE, 8'hFF);
    rdchk(`PPM_OFS_DEBOUNCE, 8'hFF, 8'h0F);
    wr(`PPM_OFS_CTRL, 8'h80);
    cyc(2);
    chk({7'h00, stb_oe}, 8'h01);
    wr(`PPM_OFS_CTRL, 8'h00);
    cyc(2);
    chk({7'h00, stb_oe}, 8'h00);
  endtask

  task automatic t_shutdown;
    wr(`PPM_OFS_CTRL, 8'h61);
    await(3, 1'h1, 300);
    chk({7'h00, monitor_en}, 8'h01);
    shdn_low <= 1'h1;
    await(1, 1'h1, 10);
    chk({7'h00, monitor_en}, 8'h00);
    rdchk(`PPM_OFS_CTRL, 8'hFF, 8'h01);
    await(4, 1'h1, 300);
    shdn_low <= 1'h0;
    cyc(10);
    rdchk(`PPM_OFS_CTRL, 8'hFF, 8'h01);
    chk({7'h00, refresh_halt}, 8'h01);
    wr(`PPM_OFS_CTRL, 8'h61);
    await(1, 1'h0, 4);
    await(3, 1'h1, 300);
  endtask

  task automatic t_standby_in;
    stb_lvl <= 1'h1;
    await(0, 1'h1, 20);
    await(4, 1'h1, 300);
    chk({7'h00, stb_oe}, 8'h00);
    stb_lvl <= 1'h0;
    await(0, 1'h0, 20);
    await(3, 1'h1, 300);
  endtask

  task automatic t_timer;
    wr(`PPM_OFS_CTRL, 8'hC1);
    ac <= 1'h1;
    wr(`PPM_OFS_TIMEOUT, 8'h03);
    cyc(100);
    chk({7'h00, standby_mode}, 8'h00);
    ac <= 1'h0;
    await(0, 1'h1, 60);
    cyc(2);
    chk({6'h00, stb_out, stb_in}, 8'h03);
    pulse_act();
    await(0, 1'h0, 20);
    cyc(2);
    chk({7'h00, stb_out}, 8'h00);
    wr(`PPM_OFS_CTRL, 8'hC0);
    await(0, 1'h1, 60);
    pulse_act();
    cyc(20);
    chk({7'h00, standby_mode}, 8'h01);
    wr(`PPM_OFS_TIMEOUT, 8'h00);
    await(0, 1'h0, 20);
  endtask

  task automatic t_suspend;
    wr(`PPM_OFS_DEBOUNCE, 8'h02);
    susp <= 1'h1;
    await(2, 1'h1, 80);
    await(4, 1'h1, 300);
    susp <= 1'h0;
    await(2, 1'h0, 80);
    wr(`PPM_OFS_POLARITY, 8'h08);
    await(2, 1'h1, 80);
    wr(`PPM_OFS_POLARITY, 8'h00);
    await(2, 1'h0, 80);
    chk({7'h00, order_err}, 8'h00);
  endtask

  // Main sequence: two-cycle reset, then each scenario in turn
  initial
  begin
    cyc(2);
    rst_n <= 1'h1;
    t_regs();
    t_shutdown();
    t_standby_in();
    t_timer();
    t_suspend();
    end_of_test();
  end

  // Watchdog well beyond the longest expected run
  initial
  begin
    #200000;
    errors++;
    end_of_test();
  end
endmodule
